//--- tb/ecp_fifo_dma_irq_control_tb_top.sv
/*
 * Self-checking bench for the ECP port data path with a peripheral model.
 * Assumes ecpf_pkg, ecpf_port and ecpf_peer_model are compiled first.
 */
module ecp_fifo_dma_irq_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ecpf_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic req;
	logic dack_n = 1'b1;
	logic tc = 1'b0;
	logic irq;
	logic irq_oe;
	logic dir = 1'b0;
	logic [3:0] lvl = 4'hf;
	logic [3:0] lag = 4'h3;
	logic [3:0] man = 4'hf;
	logic ack_en = 1'b0;
	logic fault_n = 1'b1;
	logic [7:0] pd_h;
	logic [7:0] pd_p;
	logic pd_oe;
	logic [3:0] ctl_n;
	logic [3:0] ctl_oe;
	logic ack_n;
	logic busy;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	int irq_cyc = 0;

	always #4 clk = ~clk;

	ecpf_port i_dut (
		.clk_sys_i(clk), .sys_rst_i(rst), .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd),
		.io_wdata_i(wdata), .io_rdata_o(rdata), .port_xfer_request_o(req),
		.port_xfer_acknowledge_low_i(dack_n), .dma_tc_i(tc), .port_irq_line_o(irq),
		.port_irq_line_oe_o(irq_oe), .direction_i(dir), .fifo_level_setting_i(lvl),
		.acknowledge_irq_enable_i(ack_en), .ctl_manual_i(man), .pd_i(pd_p), .pd_o(pd_h),
		.pd_oe_o(pd_oe), .ctl_n_o(ctl_n), .ctl_n_oe_o(ctl_oe), .ack_n_i(ack_n),
		.busy_i(busy), .fault_n_i(fault_n)
	);
	ecpf_peer_model i_peer (
		.clk_sys_i(clk), .dir_i(dir), .lag_i(lag), .host_pd_i(pd_h), .host_ctl_n_i(ctl_n),
		.pd_o(pd_p), .busy_o(busy), .ack_n_o(ack_n)
	);

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	// Only cycles where the line is really pulled low count as interrupt time.
	always @(negedge clk) begin
		cyc++;
		if (irq_oe === 1'b1 && irq === 1'b0) begin
			irq_cyc++;
		end
		if (cyc == 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wreg

	task automatic rreg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : rreg

	task automatic pulses(input int base, input int exp);
		repeat (40) @(negedge clk);
		chk(9'(irq_cyc - base), 9'(exp));
	endtask : pulses

	task automatic wait_peer;
		int t;
		t = 0;
		while ((i_peer.rev_send.size() > 0 || i_peer.active) && t < 500) begin
			@(negedge clk);
			t++;
		end
		repeat (6) @(negedge clk);
	endtask : wait_peer

	task automatic dma_rd(input logic last, input logic [7:0] exp);
		int t;
		t = 0;
		while (req !== 1'b1 && t < 500) begin
			@(negedge clk);
			t++;
		end
		dack_n = 1'b0;
		rd = 1'b1;
		tc = last;
		@(negedge clk);
		dack_n = 1'b1;
		rd = 1'b0;
		tc = 1'b0;
		if (last) chk(9'(req), 9'h000);
		@(negedge clk);
		chk(9'(rdata), 9'(exp));
	endtask : dma_rd

	task automatic t_reset;
		logic [7:0] d;
		man = 4'h5;
		wreg(ADDR_DATA_FIFO, 8'h77);
		rreg(ADDR_CTRL, d);
		chk(9'(d), 9'h015);
		chk(9'(ctl_n), 9'h005);
		chk(9'(ctl_oe), 9'h00a);
		chk(9'(req), 9'h000);
		man = 4'hf;
		$display("t_reset done");
	endtask : t_reset

	task automatic t_pin_irq;
		int b;
		b = irq_cyc;
		fault_n = 1'b0;
		pulses(b, 0);
		b = irq_cyc;
		wreg(ADDR_CTRL, 8'h04);
		pulses(b, IRQ_PULSE_CYC);
		fault_n = 1'b1;
		repeat (2) @(negedge clk);
		b = irq_cyc;
		fault_n = 1'b0;
		pulses(b, IRQ_PULSE_CYC);
		fault_n = 1'b1;
		wreg(ADDR_CTRL, 8'h14);
		$display("t_pin_irq done");
	endtask : t_pin_irq

	task automatic t_forward;
		logic [8:0] exp_f[3] = '{9'h005, 9'h13c, 9'h08a};
		int t;
		t = 0;
		wreg(ADDR_CTRL, 8'h74);
		chk(9'(ctl_oe), 9'h00f);
		wreg(ADDR_CMD_FIFO, 8'h05);
		wreg(ADDR_DATA_FIFO, 8'h3c);
		wreg(ADDR_CMD_FIFO, 8'h8a);
		while (i_peer.fwd_got.size() < 3 && t < 500) begin
			@(negedge clk);
			t++;
		end
		foreach (exp_f[k]) chk(i_peer.fwd_got[k], exp_f[k]);
		$display("t_forward done");
	endtask : t_forward

	task automatic t_fwd_irq;
		logic [7:0] d;
		int b;
		b = irq_cyc;
		wreg(ADDR_CTRL, 8'h70);
		pulses(b, IRQ_PULSE_CYC);
		rreg(ADDR_CTRL, d);
		chk(9'(d), 9'h075);
		$display("t_fwd_irq done");
	endtask : t_fwd_irq

	task automatic t_reverse;
		logic [7:0] d;
		int b;
		wreg(ADDR_CTRL, 8'h34);
		dir = 1'b1;
		lag = 4'h0;
		wreg(ADDR_CTRL, 8'h74);
		ack_en = 1'b1;
		b = irq_cyc;
		i_peer.rev_send.push_back(9'h002);
		i_peer.rev_send.push_back(9'h1a5);
		wait_peer();
		chk(9'(irq_cyc - b), 9'(2 * IRQ_PULSE_CYC));
		ack_en = 1'b0;
		lvl = 4'h3;
		b = irq_cyc;
		wreg(ADDR_CTRL, 8'h70);
		pulses(b, 0);
		b = irq_cyc;
		lvl = 4'h2;
		pulses(b, IRQ_PULSE_CYC);
		repeat (3) begin
			rreg(ADDR_DATA_FIFO, d);
			chk(9'(d), 9'h0a5);
		end
		rreg(ADDR_CTRL, d);
		chk(9'(d), 9'h075);
		$display("t_reverse done");
	endtask : t_reverse

	task automatic t_dma;
		logic [7:0] d;
		int b;
		wreg(ADDR_CTRL, 8'h78);
		chk(9'(req), 9'h000);
		i_peer.rev_send.push_back(9'h111);
		i_peer.rev_send.push_back(9'h122);
		dma_rd(1'b0, 8'h11);
		b = irq_cyc;
		dma_rd(1'b1, 8'h22);
		pulses(b, IRQ_PULSE_CYC);
		rreg(ADDR_CTRL, d);
		chk(9'(d), 9'h07d);
		i_peer.rev_send.push_back(9'h133);
		wait_peer();
		chk(9'(req), 9'h000);
		wreg(ADDR_CTRL, 8'h78);
		chk(9'(req), 9'h001);
		dma_rd(1'b1, 8'h33);
		$display("t_dma done");
	endtask : t_dma

	task automatic t_burst;
		int hi;
		hi = 0;
		i_peer.rev_send.push_back(9'h07f);
		i_peer.rev_send.push_back(9'h1c3);
		wait_peer();
		wreg(ADDR_CTRL, 8'h78);
		repeat (DMA_BURST_MAX) dma_rd(1'b0, 8'hc3);
		repeat (40) begin
			@(negedge clk);
			if (req !== 1'b0) hi++;
		end
		chk(9'(hi), 9'h000);
		repeat (8) @(negedge clk);
		chk(9'(req), 9'h001);
		$display("t_burst done");
	endtask : t_burst

	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_pin_irq();
		t_forward();
		t_fwd_irq();
		t_reverse();
		t_dma();
		t_burst();
		give_verdict();
	end
endmodule : ecp_fifo_dma_irq_control_tb_top

//--- tb/ecpf_peer_model.sv
/*
 * Behavioural ECP peripheral: takes forward bytes with their HostAck level and sends
 * queued reverse bytes. Assumes nStrobe and nAutoFd sit at the package pin positions.
 */
module ecpf_peer_model
	import ecpf_pkg::*;
(
	input wire logic clk_sys_i, // system clock
	input wire logic dir_i, // 0 forward, 1 reverse
	input wire logic [3:0] lag_i, // extra cycles before each answer
	input wire logic [7:0] host_pd_i, // data pins from the host
	input wire logic [3:0] host_ctl_n_i, // host control pin levels
	output logic [7:0] pd_o, // data pins to the host
	output logic busy_o, // busy, or PeriphAck in reverse
	output logic ack_n_o // peripheral clock
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] fwd_got[$];
	logic [8:0] rev_send[$];
	logic [8:0] cur;
	bit active = 1'b0;
	initial begin
		pd_o = 8'h00;
		busy_o = 1'b0;
		ack_n_o = 1'b1;
		forever begin
			@(posedge clk_sys_i);
			if (!dir_i && host_ctl_n_i[PIN_STROBE] === 1'b0) begin
				fwd_got.push_back({host_ctl_n_i[PIN_AUTOFD], host_pd_i});
				repeat (lag_i) @(posedge clk_sys_i);
				busy_o <= 1'b1;
				while (host_ctl_n_i[PIN_STROBE] !== 1'b1) @(posedge clk_sys_i);
				busy_o <= 1'b0;
			end else if (dir_i && host_ctl_n_i[PIN_AUTOFD] === 1'b0 && rev_send.size() > 0) begin
				active = 1'b1;
				cur = rev_send.pop_front();
				{busy_o, pd_o} <= cur;
				repeat (lag_i) @(posedge clk_sys_i);
				@(posedge clk_sys_i);
				ack_n_o <= 1'b0;
				while (host_ctl_n_i[PIN_AUTOFD] !== 1'b1) @(posedge clk_sys_i);
				ack_n_o <= 1'b1;
				@(posedge clk_sys_i);
				// Hold is over, so stale data is scrambled to expose a late sample.
				pd_o <= ~cur[7:0];
				active = 1'b0;
			end
		end
	end
endmodule : ecpf_peer_model

//--- verilog/ecpf_fifo.sv
/*
 * Shared port FIFO: byte plus a command tag bit, occupancy count, full and empty.
 * Assumes callers never push when full or pop when empty; such requests are ignored.
 */
module ecpf_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = ecpf_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys_i, // system clock
	input wire logic sys_rst_i, // synchronous reset, high
	input wire logic flush_i, // empties the FIFO
	input wire logic push_i, // write strobe
	input wire logic [WIDTH-1:0] push_data_i, // write data
	input wire logic pop_i, // read strobe
	output logic [WIDTH-1:0] head_o, // oldest entry
	output logic [$clog2(DEPTH+1)-1:0] count_o, // occupancy
	output logic full_o, // no free entry
	output logic empty_o // no entry
);
	import ecpf_pkg::*;
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic do_push, do_pop;

	assign do_push = push_i && !full_o;
	assign do_pop = pop_i && !empty_o;
	assign full_o = (cnt_q == CW'(DEPTH));
	assign empty_o = (cnt_q == '0);
	assign count_o = cnt_q;
	assign head_o = mem_q[rp_q];

	always_comb begin
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		if (flush_i) begin
			wp_d = '0;
			rp_d = '0;
			cnt_d = '0;
		end else begin
			if (do_push) begin
				wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			end
			if (do_pop) begin
				rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
			end
			cnt_d = cnt_q + CW'(do_push) - CW'(do_pop);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
		if (do_push && !flush_i) begin
			mem_q[wp_q] <= push_data_i;
		end
	end

	property p_fifo_bounded;
		@(posedge clk_sys_i) disable iff (sys_rst_i) cnt_q <= CW'(DEPTH);
	endproperty
	a_fifo_bounded: assert property (p_fifo_bounded) else $error("fifo count beyond depth");
endmodule : ecpf_fifo

//--- verilog/ecpf_irq_pulse.sv
/*
 * Shareable interrupt line driver: a short low pulse per event, then released.
 * Assumes an external pull-up holds the shared line high while released.
 */
module ecpf_irq_pulse #(
	parameter int unsigned PULSE = ecpf_pkg::IRQ_PULSE_CYC
) (
	input wire logic clk_sys_i, // system clock
	input wire logic sys_rst_i, // synchronous reset, high
	input wire logic trig_i, // one-cycle interrupt event
	output logic line_o, // driven level, always low
	output logic line_oe_o // high while pulling the line low
);
	import ecpf_pkg::*;
	localparam int unsigned PW = $clog2(PULSE + 1);

	logic [PW-1:0] cnt_q, cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (trig_i) begin
			cnt_d = PW'(PULSE);
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// The line is never driven high, so other sources can share it.
	assign line_o = 1'b0;
	assign line_oe_o = (cnt_q != '0);

	// A new event restarts the count, so only a quiet stretch lets the pulse end.
	sequence s_low_pulse;
		line_oe_o [*4];
	endsequence
	sequence s_quiet;
		!trig_i [*4];
	endsequence
	property p_pulse_shape;
		@(posedge clk_sys_i) disable iff (sys_rst_i) trig_i |=> s_low_pulse;
	endproperty
	a_pulse_shape: assert property (p_pulse_shape) else $error("irq pulse length wrong");
	property p_pulse_end;
		@(posedge clk_sys_i) disable iff (sys_rst_i) trig_i ##1 s_quiet |=> !line_oe_o;
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("irq line held too long");
endmodule : ecpf_irq_pulse

//--- verilog/ecpf_pkg.sv
/*
 * Shared constants for the extended-capabilities parallel port data path:
 * register addresses, control register layout, mode codes, link states and timing.
 * Assumes a single 125 MHz system clock.
 */
package ecpf_pkg;
	localparam int unsigned CLK_PERIOD_PS = 8000;
	localparam int unsigned DACK_IDLE_NS = 350;
	localparam int unsigned DACK_IDLE_CYC = (DACK_IDLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned DMA_BURST_MAX = 32;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned IRQ_PULSE_CYC = 4;
	localparam int unsigned ADDR_W = 11;
	localparam logic [ADDR_W-1:0] ADDR_CMD_FIFO = 11'h000;
	localparam logic [ADDR_W-1:0] ADDR_DATA_FIFO = 11'h400;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 11'h402;
	localparam logic [2:0] MODE_STD = 3'h0;
	localparam logic [2:0] MODE_PS2 = 3'h1;
	localparam logic [2:0] MODE_FIFO = 3'h2;
	localparam logic [2:0] MODE_ECP = 3'h3;
	localparam logic [2:0] MODE_TEST = 3'h6;
	localparam int unsigned CTL_MODE_LSB = 5;
	localparam int unsigned CTL_FAULT_EN_BIT = 4;
	localparam int unsigned CTL_DMA_EN_BIT = 3;
	localparam int unsigned CTL_SID_BIT = 2;
	localparam int unsigned CTL_FULL_BIT = 1;
	localparam int unsigned CTL_EMPTY_BIT = 0;
	localparam int unsigned CMD_KIND_BIT = 7;
	localparam logic [2:0] MODE_RST = MODE_STD;
	localparam logic SID_RST = 1'b1;
	localparam logic DMA_EN_RST = 1'b0;
	localparam logic FAULT_EN_LOW_RST = 1'b1;
	localparam int unsigned PIN_STROBE = 0;
	localparam int unsigned PIN_AUTOFD = 1;
	localparam int unsigned PIN_INIT = 2;
	localparam int unsigned PIN_SELIN = 3;
	typedef enum logic [2:0] {
		LNK_IDLE,
		LNK_FWD_STB,
		LNK_FWD_REL,
		LNK_REV_RDY,
		LNK_REV_RPT,
		LNK_REV_REL
	} ecpf_link_t;
endpackage : ecpf_pkg

//--- verilog/ecpf_port.sv
/*
 * ECP parallel port data path: FIFO ports at their I/O addresses, control register,
 * forward and reverse link handshake with run-length expansion, DMA request with
 * burst limit and terminal count, and the pulsed shareable service interrupt.
 * Assumes all inputs are synchronous to clk_sys_i and I/O strobes last one cycle.
 */
// Contract
// - Forward HostAck high data, low command.
// - Command bit 7 picks run-length or channel.
// - Reverse PeriphAck high data, low command.
// - Run-length count n yields n+1 bytes.
// - Control drivers open-collector only in standard mode.
// - Disable bit blocks DMA requests and the service and terminal count interrupts.
// - Clearing disable with condition pending interrupts immediately.
// - Interrupt is brief low pulse, then released.
// - Terminal count interrupts when DMA enabled.
// - Forward PIO interrupts on enough free bytes.
// - Reverse PIO interrupts on enough held bytes.
// - Fault falling edge or enable clear interrupts.
// - Acknowledge rising edge interrupts when enabled.
// - FIFO idle after reset, used in FIFO modes.
// - Threshold is field plus one, sixteen acts fifteen.
// - Terminal count sets the disable bit itself.
// - Request at most 32 transfers, then 350 ns gap.
// - Acknowledge selects FIFO directly, single byte transfers.
// - Reverse request drops on empty or terminal count.
// - Request returns with data, after TC re-enable too.
// - Mode 011, and mode 010 in forward only, start automatic FIFO handshake.
module ecpf_port (
	input wire logic clk_sys_i, // system clock, 125 MHz
	input wire logic sys_rst_i, // synchronous reset, high
	input wire logic [ecpf_pkg::ADDR_W-1:0] io_addr_i, // I/O address
	input wire logic io_wr_i, // I/O or DMA write strobe
	input wire logic io_rd_i, // I/O or DMA read strobe
	input wire logic [7:0] io_wdata_i, // write data
	output logic [7:0] io_rdata_o, // read data, valid the cycle after the strobe
	output logic port_xfer_request_o, // DMA request
	input wire logic port_xfer_acknowledge_low_i, // DMA acknowledge, low active
	input wire logic dma_tc_i, // DMA terminal count
	output logic port_irq_line_o, // interrupt line level
	output logic port_irq_line_oe_o, // interrupt line enable
	input wire logic direction_i, // 0 forward, 1 reverse
	input wire logic [3:0] fifo_level_setting_i, // threshold field
	input wire logic acknowledge_irq_enable_i, // nAck rising-edge interrupt enable
	input wire logic [3:0] ctl_manual_i, // control pin levels in modes 000 and 001
	input wire logic [7:0] pd_i, // data pins in
	output logic [7:0] pd_o, // data pins out
	output logic pd_oe_o, // data pins enable
	output logic [3:0] ctl_n_o, // strobe, autofd, init, selectin levels
	output logic [3:0] ctl_n_oe_o, // control pin enables
	input wire logic ack_n_i, // nAck, peripheral clock in ECP
	input wire logic busy_i, // busy, peripheral acknowledge in ECP
	input wire logic fault_n_i // nFault
);
	import ecpf_pkg::*;
	localparam int unsigned CW = $clog2(FIFO_DEPTH + 1);
	localparam int unsigned BW = $clog2(DMA_BURST_MAX + 1);
	localparam int unsigned IW = $clog2(DACK_IDLE_CYC + 1);

	logic [2:0] mode_q, mode_d;
	logic sid_q, sid_d, dma_en_q, dma_en_d, fault_en_low_q, fault_en_low_d;
	logic [7:0] rdata_q, rdata_d;
	logic fault_prev_q, ack_prev_q;
	ecpf_link_t lnk_q, lnk_d;
	logic [7:0] out_q, out_d;
	logic hack_q, hack_d, stb_q, stb_d;
	logic [6:0] rle_q, rle_d, rpt_q, rpt_d;
	logic [BW-1:0] burst_q, burst_d;
	logic [IW-1:0] idle_q, idle_d;
	logic hold_q, hold_d;

	logic [8:0] head, push_data;
	logic [CW-1:0] count;
	logic full, empty, push, pop, flush;
	logic lpush, lpop;
	logic [8:0] lpush_data;
	logic dack, xfer, io_wr, io_rd, link_on, fifo_mode, dma_want;
	logic [CW-1:0] thr, free;
	logic svc_cond, svc_event, tc_event, fault_event, ack_event, irq_trig;
	logic [3:0] lvl;

	assign dack = !port_xfer_acknowledge_low_i;
	// The acknowledge alone selects the FIFO; the address is not looked at.
	assign xfer = dack && (io_rd_i || io_wr_i);
	assign io_wr = !dack && io_wr_i;
	assign io_rd = !dack && io_rd_i;
	assign fifo_mode = (mode_q == MODE_FIFO) || (mode_q == MODE_ECP);
	assign link_on = (mode_q == MODE_ECP) || ((mode_q == MODE_FIFO) && !direction_i);
	assign flush = (mode_q == MODE_STD);

	ecpf_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.flush_i(flush),
		.push_i(push),
		.push_data_i(push_data),
		.pop_i(pop),
		.head_o(head),
		.count_o(count),
		.full_o(full),
		.empty_o(empty)
	);

	// Host side FIFO traffic; the tag bit marks a command byte.
	always_comb begin
		push = 1'b0;
		push_data = {1'b0, io_wdata_i};
		pop = lpop;
		if (lpush) begin
			push = 1'b1;
			push_data = lpush_data;
		end else if (xfer && io_wr_i) begin
			push = 1'b1;
		end else if (io_wr && (io_addr_i == ADDR_CMD_FIFO) && (mode_q == MODE_ECP)
				&& !direction_i) begin
			push = 1'b1;
			push_data = {1'b1, io_wdata_i};
		end else if (io_wr && (io_addr_i == ADDR_DATA_FIFO)
				&& ((fifo_mode && !direction_i) || (mode_q == MODE_TEST))) begin
			push = 1'b1;
		end
		if ((xfer && io_rd_i) || (io_rd && (io_addr_i == ADDR_DATA_FIFO)
				&& ((fifo_mode && direction_i) || (mode_q == MODE_TEST)))) begin
			pop = 1'b1;
		end
	end

	// Link handshake: forward drains the FIFO, reverse fills it with run-length expansion.
	always_comb begin
		lnk_d = lnk_q;
		out_d = out_q;
		hack_d = hack_q;
		stb_d = stb_q;
		rle_d = rle_q;
		rpt_d = rpt_q;
		lpush = 1'b0;
		lpop = 1'b0;
		lpush_data = {1'b0, out_q};
		if (!link_on) begin
			lnk_d = LNK_IDLE;
			stb_d = 1'b1;
			hack_d = 1'b1;
		end else begin
			case (lnk_q)
				LNK_IDLE: begin
					if (!direction_i && !empty) begin
						out_d = head[7:0];
						hack_d = !head[8];
						stb_d = 1'b0;
						lpop = 1'b1;
						lnk_d = LNK_FWD_STB;
					end else if (direction_i && !full) begin
						hack_d = 1'b0;
						lnk_d = LNK_REV_RDY;
					end
				end
				LNK_FWD_STB: begin
					if (busy_i) begin
						stb_d = 1'b1;
						lnk_d = LNK_FWD_REL;
					end
				end
				LNK_FWD_REL: begin
					if (!busy_i) begin
						lnk_d = LNK_IDLE;
					end
				end
				LNK_REV_RDY: begin
					if (!ack_n_i) begin
						hack_d = 1'b1;
						out_d = pd_i;
						if (busy_i) begin
							lpush = 1'b1;
							lpush_data = {1'b0, pd_i};
							rpt_d = rle_q;
							rle_d = '0;
							lnk_d = (rle_q != '0) ? LNK_REV_RPT : LNK_REV_REL;
						end else begin
							// Reverse channel addresses are not supported and are dropped.
							if (!pd_i[CMD_KIND_BIT]) begin
								rle_d = pd_i[6:0];
							end
							lnk_d = LNK_REV_REL;
						end
					end
				end
				LNK_REV_RPT: begin
					if (!full) begin
						lpush = 1'b1;
						rpt_d = rpt_q - 1'b1;
						if (rpt_q == 7'h01) begin
							lnk_d = LNK_REV_REL;
						end
					end
				end
				LNK_REV_REL: begin
					if (ack_n_i) begin
						lnk_d = LNK_IDLE;
					end
				end
				default: begin
					lnk_d = LNK_IDLE;
				end
			endcase
		end
	end

	// Threshold and service condition.
	always_comb begin
		thr = CW'(fifo_level_setting_i) + 1'b1;
		if (thr == CW'(FIFO_DEPTH)) begin
			thr = CW'(FIFO_DEPTH - 1);
		end
		free = CW'(FIFO_DEPTH) - count;
		svc_cond = fifo_mode && !dma_en_q
			&& (direction_i ? (count >= thr) : (free >= thr));
	end

	// A pending condition fires as soon as the disable bit reads 0.
	assign svc_event = !sid_q && svc_cond;
	assign tc_event = xfer && dma_tc_i && dma_en_q && !sid_q;
	assign fault_event = !fault_n_i && ((!fault_en_low_q && fault_prev_q)
		|| (fault_en_low_q && !fault_en_low_d));
	assign ack_event = acknowledge_irq_enable_i && !ack_prev_q && ack_n_i;
	assign irq_trig = svc_event || tc_event || fault_event || ack_event;

	ecpf_irq_pulse #(
		.PULSE(IRQ_PULSE_CYC)
	) u_irq (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.trig_i(irq_trig),
		.line_o(port_irq_line_o),
		.line_oe_o(port_irq_line_oe_o)
	);

	// DMA request; dropped combinationally on the strobe of the last byte.
	assign dma_want = fifo_mode && dma_en_q && !sid_q && (direction_i ? !empty : !full);
	assign port_xfer_request_o = dma_want && !hold_q && !(dack && dma_tc_i)
		&& !(xfer && (direction_i ? (count == CW'(1)) : (count == CW'(FIFO_DEPTH - 1))));

	// Control register, burst limit and read data.
	always_comb begin
		mode_d = mode_q;
		dma_en_d = dma_en_q;
		sid_d = sid_q;
		fault_en_low_d = fault_en_low_q;
		rdata_d = rdata_q;
		burst_d = burst_q;
		idle_d = idle_q;
		hold_d = hold_q;
		if (io_wr && (io_addr_i == ADDR_CTRL)) begin
			// Extended modes may only return to 000 or 001.
			if ((mode_q == MODE_STD) || (mode_q == MODE_PS2)
					|| (io_wdata_i[CTL_MODE_LSB +: 3] == MODE_STD)
					|| (io_wdata_i[CTL_MODE_LSB +: 3] == MODE_PS2)) begin
				mode_d = io_wdata_i[CTL_MODE_LSB +: 3];
			end
			fault_en_low_d = io_wdata_i[CTL_FAULT_EN_BIT];
			dma_en_d = io_wdata_i[CTL_DMA_EN_BIT];
			sid_d = io_wdata_i[CTL_SID_BIT];
		end
		if (svc_event || tc_event) begin
			sid_d = 1'b1;
		end
		if (io_rd) begin
			rdata_d = '0;
			if (io_addr_i == ADDR_DATA_FIFO) begin
				rdata_d = head[7:0];
			end else if (io_addr_i == ADDR_CTRL) begin
				rdata_d = {mode_q, fault_en_low_q, dma_en_q, sid_q, full, empty};
			end
		end else if (xfer && io_rd_i) begin
			rdata_d = head[7:0];
		end
		if (hold_q) begin
			idle_d = dack ? '0 : idle_q + 1'b1;
			if (!dack && (idle_q == IW'(DACK_IDLE_CYC - 1))) begin
				hold_d = 1'b0;
				burst_d = '0;
			end
		end else if (!dma_want) begin
			burst_d = '0;
		end else if (xfer) begin
			burst_d = burst_q + 1'b1;
			if (burst_q == BW'(DMA_BURST_MAX - 1)) begin
				hold_d = 1'b1;
				idle_d = '0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			mode_q <= MODE_RST;
			sid_q <= SID_RST;
			dma_en_q <= DMA_EN_RST;
			fault_en_low_q <= FAULT_EN_LOW_RST;
			rdata_q <= '0;
			fault_prev_q <= 1'b1;
			ack_prev_q <= 1'b1;
			lnk_q <= LNK_IDLE;
			out_q <= '0;
			hack_q <= 1'b1;
			stb_q <= 1'b1;
			rle_q <= '0;
			rpt_q <= '0;
			burst_q <= '0;
			idle_q <= '0;
			hold_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			sid_q <= sid_d;
			dma_en_q <= dma_en_d;
			fault_en_low_q <= fault_en_low_d;
			rdata_q <= rdata_d;
			fault_prev_q <= fault_n_i;
			ack_prev_q <= ack_n_i;
			lnk_q <= lnk_d;
			out_q <= out_d;
			hack_q <= hack_d;
			stb_q <= stb_d;
			rle_q <= rle_d;
			rpt_q <= rpt_d;
			burst_q <= burst_d;
			idle_q <= idle_d;
			hold_q <= hold_d;
		end
	end

	assign io_rdata_o = rdata_q;
	assign pd_o = out_q;
	assign pd_oe_o = (mode_q == MODE_STD) || !direction_i;
	assign lvl[PIN_STROBE] = link_on ? stb_q : ctl_manual_i[PIN_STROBE];
	assign lvl[PIN_AUTOFD] = link_on ? hack_q : ctl_manual_i[PIN_AUTOFD];
	assign lvl[PIN_INIT] = link_on ? !direction_i : ctl_manual_i[PIN_INIT];
	assign lvl[PIN_SELIN] = link_on ? 1'b1 : ctl_manual_i[PIN_SELIN];

	for (genvar i = 0; i < 4; i++) begin : g_ctl_drv
		assign ctl_n_o[i] = lvl[i];
		// Standard mode only pulls low; the cable pull-up gives the high level.
		assign ctl_n_oe_o[i] = (mode_q == MODE_STD) ? !lvl[i] : 1'b1;
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_irq_soon;
		##1 port_irq_line_oe_o;
	endsequence
	property p_sid_blocks;
		sid_q |-> !port_xfer_request_o && !svc_event && !tc_event;
	endproperty
	a_sid_blocks: assert property (p_sid_blocks) else $error("request while disabled");
	property p_tc_sets_sid;
		tc_event |=> sid_q ##0 !port_xfer_request_o;
	endproperty
	a_tc_sets_sid: assert property (p_tc_sets_sid) else $error("tc left requests on");
	property p_tc_irq;
		tc_event |-> s_irq_soon;
	endproperty
	a_tc_irq: assert property (p_tc_irq) else $error("no interrupt on tc");
	property p_svc_clear;
		$fell(sid_q) && svc_cond |-> s_irq_soon;
	endproperty
	a_svc_clear: assert property (p_svc_clear) else $error("no interrupt on re-enable");
	property p_burst_limit;
		burst_q == BW'(DMA_BURST_MAX) |-> !port_xfer_request_o;
	endproperty
	a_burst_limit: assert property (p_burst_limit) else $error("burst over limit");
	property p_hold_gap;
		$rose(hold_q) |-> !port_xfer_request_o [*8];
	endproperty
	a_hold_gap: assert property (p_hold_gap) else $error("request inside gap");
	property p_fault_irq;
		!fault_en_low_q && $fell(fault_n_i) |-> s_irq_soon;
	endproperty
	a_fault_irq: assert property (p_fault_irq) else $error("no fault interrupt");
	property p_ack_irq;
		acknowledge_irq_enable_i && $rose(ack_n_i) |-> s_irq_soon;
	endproperty
	a_ack_irq: assert property (p_ack_irq) else $error("no ack interrupt");
	property p_open_col;
		mode_q == MODE_STD |-> (ctl_n_oe_o & ctl_n_o) == 4'h0;
	endproperty
	a_open_col: assert property (p_open_col) else $error("standard mode drives high");
	property p_rle_repeat;
		lnk_q == LNK_REV_RPT && !full |-> lpush && lpush_data[7:0] == out_q;
	endproperty
	a_rle_repeat: assert property (p_rle_repeat) else $error("repeat byte not pushed");
endmodule : ecpf_port
